// File: src/gpt_timer.sv
`timescale 1ns/100ps
// Operation
// - new load in immediate mode goes straight into a running counter
// - 16/32 or 32/64 pairs; joined wide values go through half A words
// - match raises capture-count interrupt and sets pwm duty
// - match interrupt also in periodic and one-shot when enabled
// - prescaler only counts in split mode, ignored when joined
// - prescaler is low bits in periodic/one-shot, high bits otherwise
// - prescale match widens the match value in split mode
// - prescale fields hold 0..255 narrow or 0..65535 wide
// - clearing rtc enable halts a counter in rtc mode
// - rtc enable only starts counting in rtc mode
// - sync command from first module pulses all selected halves together
// - split halves join the sync event independently
// - joined timer syncs through A only, B select ignored
// - load update setting: immediate or held until count reaches zero
// - match update setting: immediate or deferred until count reaches zero
// - deferred updates only matter when counting down
// - value read gives present count of half or joined count
// - match read gives last programmed match
// - prescale and prescale match reads give programmed values
// - interrupt sources reach irq only when enabled, raw still visible
module gpt_timer #(
  parameter int WIDE = 0,  // 0: 16/32 pair, 1: 32/64 pair
  parameter int FIRST = 1  // 1: this module issues group sync
) (
  input wire logic pclk,  // 200 MHz clock
  input wire logic presetn,  // async reset, active low
  input wire logic psel,  // apb select
  input wire logic penable,  // apb access phase
  input wire logic pwrite,  // apb direction
  input wire logic [7:0] paddr,  // apb byte address
  input wire logic [31:0] pwdata,  // apb write data
  output logic [31:0] prdata,  // apb read data
  output logic pready,  // apb ready
  output logic pslverr,  // apb error on unmapped address
  input wire logic [1:0] cap_i,  // capture edge pulses per half
  input wire logic [1:0] sync_i,  // sync pulses for halves A, B
  output logic [gpt_pkg::GROUP_SYNC_BITS-1:0] group_sync_o,  // sync command mask
  output logic [1:0] pwm_o,  // pwm outputs per half
  output logic irq  // interrupt line
);
  localparam int HW = (WIDE != 0) ? 32 : 16;
  localparam int PW = (WIDE != 0) ? 16 : 8;
  localparam int XW = 2 * HW;

  generate
    if (WIDE > 1 || FIRST > 1) begin : g_bad_param
      $error("gpt_timer: WIDE and FIRST must be 0 or 1");
    end
  endgenerate

  typedef struct packed {
    logic joined;
    logic rtc_en;
    logic [1:0][7:0] ctl;
    logic [1:0][HW-1:0] cnt;
    logic [1:0][PW-1:0] pcnt;
    logic [1:0][HW-1:0] load;
    logic [1:0][PW-1:0] pre;
    logic [1:0][HW-1:0] mat;
    logic [1:0][HW-1:0] mact;
    logic [1:0][PW-1:0] pmat;
    logic [3:0] ris;
    logic [3:0] imr;
    logic [1:0] pwm;
    logic [gpt_pkg::GROUP_SYNC_BITS-1:0] gsync;
    logic [31:0] prdata;
    logic irq;
  } gpt_state_t;

  localparam gpt_state_t RST_S = '{ctl: {2{gpt_pkg::CTL_RST}}, default: '0};

  gpt_state_t s_reg;
  gpt_state_t s_next;

  // extended count of one half, prescaler placed low or high
  function automatic logic [XW-1:0] xv(input logic lsb, input logic [HW-1:0] c,
                                       input logic [PW-1:0] p);
    xv = lsb ? XW'({c, p}) : XW'({p, c});
  endfunction

  // one 32-bit word of a joined pair
  function automatic logic [31:0] jw(input logic [XW-1:0] r, input logic hi);
    logic [63:0] t;
    t = 64'(r);
    jw = hi ? t[63:32] : t[31:0];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= gpt_pkg::OFS_SYNC);
  endfunction

  // apb is zero wait state; only misaligned or out-of-map accesses fail
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata = s_reg.prdata;
  assign group_sync_o = s_reg.gsync;
  assign pwm_o = s_reg.pwm;
  assign irq = s_reg.irq;

  always_comb begin
    logic [XW-1:0] v;
    logic [XW-1:0] ld;
    logic [XW-1:0] mt;
    logic [2:0] md;
    logic down;
    logic lsb;
    logic run;
    logic tick;
    logic zero;
    logic hit;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [1:0] ldw;
    logic [1:0] mw;
    logic wr;
    logic [63:0] wd64;
    int hc;
    // every field keeps its value unless a path below changes it
    s_next = s_reg;
    v = '0;
    ld = '0;
    mt = '0;
    md = '0;
    down = 1'b0;
    lsb = 1'b0;
    run = 1'b0;
    tick = 1'b0;
    zero = 1'b0;
    hit = 1'b0;
    ev = '0;
    clr = '0;
    ldw = '0;
    mw = '0;
    hc = 0;
    wr = psel && penable && pwrite;
    wd64 = {32'h0, pwdata};
    s_next.gsync = '0;

    // counting, one pass per half; while joined A's pass counts the whole pair and B has none
    for (int h = 0; h < 2; h++) begin
      if (!(s_reg.joined && h == 1)) begin
        md = s_reg.ctl[h][2:0];
        down = (md != gpt_pkg::MODE_RTC);
        lsb = (md == gpt_pkg::MODE_ONESHOT || md == gpt_pkg::MODE_PERIODIC);
        run = s_reg.ctl[h][gpt_pkg::CTL_EN] && (down || s_reg.rtc_en);
        tick = (md == gpt_pkg::MODE_CAPCNT) ? cap_i[h] : 1'b1;
        if (s_reg.joined) begin
          v = s_reg.cnt;
          ld = s_reg.load;
          mt = s_reg.mact;
        end else begin
          v = xv(lsb, s_reg.cnt[h], s_reg.pcnt[h]);
          ld = xv(lsb, s_reg.load[h], s_reg.pre[h]);
          mt = xv(lsb, s_reg.mact[h], s_reg.pmat[h]);
        end
        zero = 1'b0;
        hit = 1'b0;
        if (sync_i[h]) begin
          v = down ? ld : '0;
        end else if (run && tick) begin
          if (!down) begin
            v = v + XW'(1);
          end else if (v == '0) begin
            zero = 1'b1;
            v = ld;
          end else begin
            v = v - XW'(1);
          end
          hit = (v == mt);
        end
        if (s_reg.joined) begin
          s_next.cnt = v;
        end else if (lsb) begin
          s_next.cnt[h] = v[PW+:HW];
          s_next.pcnt[h] = v[PW-1:0];
        end else begin
          s_next.cnt[h] = v[HW-1:0];
          s_next.pcnt[h] = v[HW+:PW];
        end
        if (zero) begin
          ev[2*h] = 1'b1;
          // deferred match applies here; equal anyway in immediate mode
          if (s_reg.joined) begin
            s_next.mact = s_reg.mat;
          end else begin
            s_next.mact[h] = s_reg.mat[h];
          end
          if (md == gpt_pkg::MODE_ONESHOT) begin
            s_next.ctl[h][gpt_pkg::CTL_EN] = 1'b0;
          end
        end
        // capture count and rtc always flag; timed modes only when enabled
        if (hit && (s_reg.ctl[h][gpt_pkg::CTL_MATCH_IE] || md == gpt_pkg::MODE_CAPCNT ||
                    md == gpt_pkg::MODE_RTC)) begin
          ev[2*h+1] = 1'b1;
        end
        s_next.pwm[h] = (md == gpt_pkg::MODE_PWM) && run && (v > mt);
      end
    end
    if (s_reg.joined) begin
      s_next.pwm[1] = 1'b0;
    end

    // register writes land after counting so a write wins over a step
    if (wr) begin
      case (paddr)
        gpt_pkg::OFS_CFG: begin
          s_next.joined = pwdata[gpt_pkg::CFG_JOIN];
          s_next.rtc_en = pwdata[gpt_pkg::CFG_RTC_EN];
        end
        gpt_pkg::OFS_CTLA: begin
          s_next.ctl[0] = pwdata[7:0];
        end
        gpt_pkg::OFS_CTLB: begin
          s_next.ctl[1] = pwdata[7:0];
        end
        gpt_pkg::OFS_LOADA: begin
          s_next.load[0] = wd64[HW-1:0];
          ldw[0] = 1'b1;
          if (s_reg.joined && WIDE == 0) begin
            s_next.load[1] = wd64[XW-1:HW];
            ldw[1] = 1'b1;
          end
        end
        gpt_pkg::OFS_LOADB: begin
          if (!s_reg.joined) begin
            s_next.load[1] = wd64[HW-1:0];
            ldw[1] = 1'b1;
          end
        end
        gpt_pkg::OFS_LOADAH: begin
          if (s_reg.joined && WIDE != 0) begin
            s_next.load[1] = wd64[HW-1:0];
            ldw[1] = 1'b1;
          end
        end
        gpt_pkg::OFS_MATA: begin
          s_next.mat[0] = wd64[HW-1:0];
          mw[0] = 1'b1;
          if (s_reg.joined && WIDE == 0) begin
            s_next.mat[1] = wd64[XW-1:HW];
            mw[1] = 1'b1;
          end
        end
        gpt_pkg::OFS_MATB: begin
          if (!s_reg.joined) begin
            s_next.mat[1] = wd64[HW-1:0];
            mw[1] = 1'b1;
          end
        end
        gpt_pkg::OFS_MATAH: begin
          if (s_reg.joined && WIDE != 0) begin
            s_next.mat[1] = wd64[HW-1:0];
            mw[1] = 1'b1;
          end
        end
        // upper data bits are dropped, the field only holds the legal range
        gpt_pkg::OFS_PREA: s_next.pre[0] = wd64[PW-1:0];
        gpt_pkg::OFS_PREB: s_next.pre[1] = wd64[PW-1:0];
        gpt_pkg::OFS_PMATA: s_next.pmat[0] = wd64[PW-1:0];
        gpt_pkg::OFS_PMATB: s_next.pmat[1] = wd64[PW-1:0];
        gpt_pkg::OFS_IMR: s_next.imr = pwdata[3:0];
        gpt_pkg::OFS_ICR: clr = pwdata[3:0];
        gpt_pkg::OFS_SYNC: begin
          if (FIRST != 0) begin
            s_next.gsync = pwdata[gpt_pkg::GROUP_SYNC_BITS-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // immediate or held load and match, per half
    for (int h = 0; h < 2; h++) begin
      hc = s_reg.joined ? 0 : h;
      md = s_reg.ctl[hc][2:0];
      down = (md != gpt_pkg::MODE_RTC);
      if (ldw[h] && s_reg.ctl[hc][gpt_pkg::CTL_EN] &&
          (s_reg.ctl[hc][gpt_pkg::CTL_LOAD_UPDATE_NOW] || !down)) begin
        s_next.cnt[h] = s_next.load[h];
        if (!s_reg.joined) begin
          s_next.pcnt[h] = s_next.pre[h];
        end
      end
      if (mw[h] && (s_reg.ctl[hc][gpt_pkg::CTL_MATCH_UPDATE_NOW] || !down)) begin
        s_next.mact[h] = s_next.mat[h];
      end
    end

    // status: a new event wins over a clear in the same cycle
    s_next.ris = (s_reg.ris & ~clr) | ev;
    s_next.irq = |(s_next.ris & s_next.imr);

    // read data sampled in the setup cycle, valid through the access cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        gpt_pkg::OFS_CFG: s_next.prdata = {30'h0, s_reg.rtc_en, s_reg.joined};
        gpt_pkg::OFS_CTLA: s_next.prdata = {24'h0, s_reg.ctl[0]};
        gpt_pkg::OFS_CTLB: s_next.prdata = {24'h0, s_reg.ctl[1]};
        gpt_pkg::OFS_LOADA: begin
          s_next.prdata = s_reg.joined ? jw(s_reg.load, 1'b0) : 32'(s_reg.load[0]);
        end
        gpt_pkg::OFS_LOADB: s_next.prdata = s_reg.joined ? 32'h0 : 32'(s_reg.load[1]);
        gpt_pkg::OFS_LOADAH: s_next.prdata = s_reg.joined ? jw(s_reg.load, 1'b1) : 32'h0;
        gpt_pkg::OFS_MATA: begin
          s_next.prdata = s_reg.joined ? jw(s_reg.mat, 1'b0) : 32'(s_reg.mat[0]);
        end
        gpt_pkg::OFS_MATB: s_next.prdata = s_reg.joined ? 32'h0 : 32'(s_reg.mat[1]);
        gpt_pkg::OFS_MATAH: s_next.prdata = s_reg.joined ? jw(s_reg.mat, 1'b1) : 32'h0;
        gpt_pkg::OFS_PREA: s_next.prdata = 32'(s_reg.pre[0]);
        gpt_pkg::OFS_PREB: s_next.prdata = 32'(s_reg.pre[1]);
        gpt_pkg::OFS_PMATA: s_next.prdata = 32'(s_reg.pmat[0]);
        gpt_pkg::OFS_PMATB: s_next.prdata = 32'(s_reg.pmat[1]);
        gpt_pkg::OFS_VALA: begin
          s_next.prdata = s_reg.joined ? jw(s_reg.cnt, 1'b0) : 32'(s_reg.cnt[0]);
        end
        gpt_pkg::OFS_VALB: s_next.prdata = s_reg.joined ? 32'h0 : 32'(s_reg.cnt[1]);
        gpt_pkg::OFS_VALAH: s_next.prdata = s_reg.joined ? jw(s_reg.cnt, 1'b1) : 32'h0;
        gpt_pkg::OFS_RIS: s_next.prdata = {28'h0, s_reg.ris};
        gpt_pkg::OFS_IMR: s_next.prdata = {28'h0, s_reg.imr};
        gpt_pkg::OFS_MIS: s_next.prdata = {28'h0, s_reg.ris & s_reg.imr};
        default: s_next.prdata = 32'h0;
      endcase
    end
  end

  // single register bank for all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= RST_S;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule  // gpt_timer

// File: common/gpt_pkg.sv
package gpt_pkg;
  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTLA = 8'h04;
  localparam logic [7:0] OFS_CTLB = 8'h08;
  localparam logic [7:0] OFS_LOADA = 8'h0c;
  localparam logic [7:0] OFS_LOADB = 8'h10;
  localparam logic [7:0] OFS_LOADAH = 8'h14;
  localparam logic [7:0] OFS_MATA = 8'h18;
  localparam logic [7:0] OFS_MATB = 8'h1c;
  localparam logic [7:0] OFS_MATAH = 8'h20;
  localparam logic [7:0] OFS_PREA = 8'h24;
  localparam logic [7:0] OFS_PREB = 8'h28;
  localparam logic [7:0] OFS_PMATA = 8'h2c;
  localparam logic [7:0] OFS_PMATB = 8'h30;
  localparam logic [7:0] OFS_VALA = 8'h34;
  localparam logic [7:0] OFS_VALB = 8'h38;
  localparam logic [7:0] OFS_VALAH = 8'h3c;
  localparam logic [7:0] OFS_RIS = 8'h40;
  localparam logic [7:0] OFS_IMR = 8'h44;
  localparam logic [7:0] OFS_ICR = 8'h48;
  localparam logic [7:0] OFS_MIS = 8'h4c;
  localparam logic [7:0] OFS_SYNC = 8'h50;
  // config word fields
  localparam int CFG_JOIN = 0;
  localparam int CFG_RTC_EN = 1;
  // per-half control word fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_EN = 3;
  localparam int CTL_LOAD_UPDATE_NOW = 4;
  localparam int CTL_MATCH_UPDATE_NOW = 5;
  localparam int CTL_MATCH_IE = 6;
  localparam logic [7:0] CTL_RST = 8'h30;
  // counting modes
  localparam logic [2:0] MODE_ONESHOT = 3'h0;
  localparam logic [2:0] MODE_PERIODIC = 3'h1;
  localparam logic [2:0] MODE_CAPCNT = 3'h2;
  localparam logic [2:0] MODE_PWM = 3'h3;
  localparam logic [2:0] MODE_RTC = 3'h4;
  // raw status bits
  localparam int RIS_TO_A = 0;
  localparam int RIS_MATCH_A = 1;
  localparam int RIS_TO_B = 2;
  localparam int RIS_MATCH_B = 3;
  // group sync mask layout
  localparam int NARROW_GROUP_SYNC_SELECT_LSB = 0;
  localparam int WIDE_GROUP_SYNC_SELECT_LSB = 12;
  localparam int GROUP_SYNC_BITS = 24;
endpackage

// File: verif/gpt_timer_chk.sv
`timescale 1ns/100ps
module gpt_timer_chk (
  input wire logic pclk,  // clock
  input wire logic presetn,  // reset, active low
  input wire logic psel,  // apb select
  input wire logic penable,  // apb access
  input wire logic pwrite,  // apb direction
  input wire logic [7:0] paddr,  // apb address
  input wire logic [31:0] pwdata,  // apb write data
  input wire logic [31:0] prdata,  // apb read data
  input wire logic pready,  // apb ready
  input wire logic [gpt_pkg::GROUP_SYNC_BITS-1:0] group_sync_o,  // sync mask
  input wire logic [1:0] pwm_o,  // pwm outputs
  input wire logic irq  // interrupt line
);
  logic wr;
  logic rd;
  logic sync_wr_reg;
  logic [23:0] sync_reg;
  logic [31:0] imr_reg;
  logic [15:0] mat_reg;
  logic [7:0] pre_reg;
  logic [2:0] mode_a_reg;
  logic [2:0] mode_b_reg;
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite;
  // shadows of what software last wrote; defaults follow reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_wr_reg <= 1'b0;
      sync_reg <= 24'h0;
      imr_reg <= 32'h0;
      mat_reg <= 16'h0;
      pre_reg <= 8'h0;
      mode_a_reg <= 3'h0;
      mode_b_reg <= 3'h0;
    end else begin
      sync_wr_reg <= wr && paddr == gpt_pkg::OFS_SYNC;
      if (wr && paddr == gpt_pkg::OFS_SYNC) sync_reg <= pwdata[23:0];
      if (wr && paddr == gpt_pkg::OFS_IMR) imr_reg <= pwdata;
      if (wr && paddr == gpt_pkg::OFS_MATA) mat_reg <= pwdata[15:0];
      if (wr && paddr == gpt_pkg::OFS_PREA) pre_reg <= pwdata[7:0];
      if (wr && paddr == gpt_pkg::OFS_CTLA) mode_a_reg <= pwdata[2:0];
      if (wr && paddr == gpt_pkg::OFS_CTLB) mode_b_reg <= pwdata[2:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sync_val;
    sync_wr_reg |-> group_sync_o == sync_reg;
  endproperty
  a_sync_val: assert property (p_sync_val) else $error("sync mask differs from write");
  property p_sync_idle;
    !sync_wr_reg |-> group_sync_o == 24'h0;
  endproperty
  a_sync_idle: assert property (p_sync_idle) else $error("sync pulse without command");
  // irq is registered from the next mask value, so it quiets in the same cycle the mask clears
  property p_irq_mask;
    imr_reg == 32'h0 && $past(imr_reg) == 32'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all sources masked");
  property p_irq_rise;
    $rose(irq) |-> imr_reg != 32'h0;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose while masked");
  property p_pwm_a;
    pwm_o[0] |-> mode_a_reg == gpt_pkg::MODE_PWM || $past(mode_a_reg) == gpt_pkg::MODE_PWM;
  endproperty
  a_pwm_a: assert property (p_pwm_a) else $error("pwm a high outside pwm mode");
  property p_pwm_b;
    pwm_o[1] |-> mode_b_reg == gpt_pkg::MODE_PWM || $past(mode_b_reg) == gpt_pkg::MODE_PWM;
  endproperty
  a_pwm_b: assert property (p_pwm_b) else $error("pwm b high outside pwm mode");
  property p_mat_rd;
    rd && paddr == gpt_pkg::OFS_MATA |-> prdata[15:0] == mat_reg;
  endproperty
  a_mat_rd: assert property (p_mat_rd) else $error("match read differs");
  property p_pre_rd;
    rd && paddr == gpt_pkg::OFS_PREA |-> prdata[7:0] == pre_reg;
  endproperty
  a_pre_rd: assert property (p_pre_rd) else $error("prescale read differs");
  c_sync: cover property (sync_wr_reg && group_sync_o != 24'h0);
  c_irq: cover property ($rose(irq));
  c_pwm: cover property ($rose(pwm_o[1]));
endmodule // gpt_timer_chk
bind gpt_timer gpt_timer_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .group_sync_o(group_sync_o), .pwm_o(pwm_o), .irq(irq));

// File: verif/tb_gpt_timer.sv
`timescale 1ns/100ps
module tb_gpt_timer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] cap_i = 2'h0;
  logic [23:0] group_sync_o;
  logic [1:0] pwm_o;
  logic irq;
  logic [31:0] got;
  logic [31:0] v;
  logic err;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  // 200 MHz
  always #2.5 pclk = ~pclk;
  // own sync response comes back from the group command
  gpt_timer #(.WIDE(0), .FIRST(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_i(cap_i), .sync_i(group_sync_o[1:0]),
    .group_sync_o(group_sync_o), .pwm_o(pwm_o), .irq(irq));
  task automatic results;
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask
  // one apb transfer; waits one edge first so back-to-back calls never re-drive psel
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    got = prdata;
    err = pslverr;
    if (pready !== 1'b1) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // watchdog, well beyond the longest deferred reload
  initial begin
    #300000;
    n_fail++;
    results();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(gpt_pkg::OFS_CTLA);
    chk("ctla_rst", 32'h30, got);
    wr(gpt_pkg::OFS_PREA, 32'hff);
    wr(gpt_pkg::OFS_PMATA, 32'h5a);
    wr(gpt_pkg::OFS_MATA, 32'h1234);
    rd(gpt_pkg::OFS_PREA);
    chk("prea", 32'hff, got);
    rd(gpt_pkg::OFS_PMATA);
    chk("pmata", 32'h5a, got);
    rd(gpt_pkg::OFS_MATA);
    chk("mata", 32'h1234, got);
    // periodic timeout reaching the line
    wr(gpt_pkg::OFS_PREA, 32'h0);
    wr(gpt_pkg::OFS_LOADA, 32'h5);
    wr(gpt_pkg::OFS_IMR, 32'h1);
    wr(gpt_pkg::OFS_CTLA, 32'h39);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("irq_on", 32'h1, {31'h0, irq});
    rd(gpt_pkg::OFS_RIS);
    chk("ris_to", 32'h1, got);
    // masked source stays raw only
    wr(gpt_pkg::OFS_IMR, 32'h0);
    wr(gpt_pkg::OFS_ICR, 32'h1);
    // one full reload period, so a fresh timeout lands after the clear
    repeat (1300) @(posedge pclk);
    rd(gpt_pkg::OFS_RIS);
    chk("ris_raw", 32'h1, got);
    chk("irq_off", 32'h0, {31'h0, irq});
    // one-shot stops and drops its enable
    wr(gpt_pkg::OFS_CTLA, 32'h30);
    wr(gpt_pkg::OFS_CTLA, 32'h38);
    // leftover count may be a whole reload period long
    repeat (1300) @(posedge pclk);
    rd(gpt_pkg::OFS_CTLA);
    chk("oneshot_stop", 32'h30, got);
    // immediate load lands in the running counter
    wr(gpt_pkg::OFS_LOADA, 32'h8000);
    wr(gpt_pkg::OFS_CTLA, 32'h39);
    wr(gpt_pkg::OFS_LOADA, 32'h100);
    rd(gpt_pkg::OFS_VALA);
    chk("load_now", 32'h1, {31'h0, got > 32'hf0 && got <= 32'h100});
    // deferred load waits for zero; the prescaler holds the low count bits
    wr(gpt_pkg::OFS_LOADA, 32'h8);
    wr(gpt_pkg::OFS_CTLA, 32'h29);
    wr(gpt_pkg::OFS_LOADA, 32'h2);
    rd(gpt_pkg::OFS_VALA);
    chk("load_held", 32'h1, {31'h0, got > 32'h2 && got <= 32'h8});
    repeat (2100) @(posedge pclk);
    rd(gpt_pkg::OFS_VALA);
    chk("load_at_zero", 32'h1, {31'h0, got <= 32'h2});
    // rtc enable only counts in rtc mode
    wr(gpt_pkg::OFS_CTLA, 32'h30);
    wr(gpt_pkg::OFS_CFG, 32'h2);
    rd(gpt_pkg::OFS_VALA);
    v = got;
    rd(gpt_pkg::OFS_VALA);
    chk("rtc_other_mode", v, got);
    wr(gpt_pkg::OFS_CFG, 32'h0);
    wr(gpt_pkg::OFS_CTLA, 32'h3c);
    rd(gpt_pkg::OFS_VALA);
    v = got;
    rd(gpt_pkg::OFS_VALA);
    chk("rtc_halt", v, got);
    wr(gpt_pkg::OFS_CFG, 32'h2);
    rd(gpt_pkg::OFS_VALA);
    v = got;
    rd(gpt_pkg::OFS_VALA);
    chk("rtc_run", 32'h1, {31'h0, got != v});
    wr(gpt_pkg::OFS_CFG, 32'h0);
    // group sync of half A only; held loads keep either half from jumping by itself
    wr(gpt_pkg::OFS_CTLA, 32'h39);
    wr(gpt_pkg::OFS_CTLB, 32'h39);
    wr(gpt_pkg::OFS_LOADA, 32'h100);
    wr(gpt_pkg::OFS_LOADB, 32'h100);
    wr(gpt_pkg::OFS_CTLA, 32'h29);
    wr(gpt_pkg::OFS_CTLB, 32'h29);
    wr(gpt_pkg::OFS_LOADA, 32'h8000);
    wr(gpt_pkg::OFS_LOADB, 32'h8000);
    wr(gpt_pkg::OFS_SYNC, 32'h1);
    rd(gpt_pkg::OFS_VALA);
    chk("sync_a", 32'h1, {31'h0, got > 32'h7f00});
    rd(gpt_pkg::OFS_VALB);
    chk("sync_b_left", 32'h1, {31'h0, got < 32'h7f00});
    // capture count on A flags the match on the second edge only
    wr(gpt_pkg::OFS_CTLA, 32'h30);
    wr(gpt_pkg::OFS_PMATA, 32'h0);
    wr(gpt_pkg::OFS_MATA, 32'h3);
    wr(gpt_pkg::OFS_CTLA, 32'h3a);
    wr(gpt_pkg::OFS_LOADA, 32'h5);
    wr(gpt_pkg::OFS_ICR, 32'hf);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      cap_i <= 2'h1;
      @(posedge pclk);
      cap_i <= 2'h0;
      rd(gpt_pkg::OFS_RIS);
      chk("capcnt_match", {30'h0, i == 1, 1'b0}, got & 32'h2);
    end
    // pwm on half B toggles with match setting the duty
    wr(gpt_pkg::OFS_CTLB, 32'h30);
    wr(gpt_pkg::OFS_MATB, 32'h4);
    wr(gpt_pkg::OFS_CTLB, 32'h3b);
    wr(gpt_pkg::OFS_LOADB, 32'ha);
    repeat (30) @(posedge pclk);
    n = 0;
    repeat (22) begin
      @(posedge pclk);
      if (pwm_o[1] === 1'b1) n++;
    end
    chk("pwm_duty", 32'h1, {31'h0, n >= 8 && n <= 14});
    // unmapped place is refused
    rd(8'h54);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, got);
    results();
  end
endmodule // tb_gpt_timer
